// file: common/sequencer_pkg.sv
// Constants and types shared by the profile step sequencer.
package sequencer_pkg;
	localparam int NUM_LOOPS = 2;
	localparam int LOOP_SEL_W = 1;
	localparam int SP_W = 16;
	localparam int STEP_W = 7;
	localparam int MAX_STEPS = 99;
	localparam int TIME_W = 20;
	localparam int FRAC_W = 16;
	localparam int ADR_W = 12;
	// ========================================================
	// Register byte addresses.
	localparam logic [ADR_W-1:0] CTRL_ADDR = 12'h000;
	localparam logic [ADR_W-1:0] CFG_ADDR = 12'h004;
	localparam logic [ADR_W-1:0] BAND_ADDR = 12'h008;
	localparam logic [ADR_W-1:0] AS_TIME_ADDR = 12'h00c;
	localparam logic [ADR_W-1:0] AS_DATE_ADDR = 12'h010;
	localparam logic [ADR_W-1:0] RUN_TIME_ADDR = 12'h014;
	localparam logic [ADR_W-1:0] RUN_DATE_ADDR = 12'h018;
	localparam logic [ADR_W-1:0] STATUS_ADDR = 12'h01c;
	localparam logic [ADR_W-1:0] TIME_LEFT_ADDR = 12'h020;
	localparam logic [ADR_W-1:0] STEP_BASE = 12'h400;
	// ========================================================
	// Control bit positions.
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_HOLD = 2;
	localparam int CTRL_AS_EN = 3;
	localparam int CTRL_SAVE = 4;
	localparam int CTRL_LOAD = 5;
	// ========================================================
	// Step duration weights and reset values.
	localparam logic [TIME_W-1:0] SECS_PER_HOUR = 20'h00e10;
	localparam logic [TIME_W-1:0] SECS_PER_MIN = 20'h0003c;
	localparam logic [STEP_W-1:0] NSTEPS_RST = 7'h01;
	localparam logic [STEP_W-1:0] START_RST = 7'h01;
	localparam logic [4:0] DIV_LAST = 5'h10;
	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_AUTO = 6'h02,
		S_INIT = 6'h04,
		S_LOAD = 6'h08,
		S_DIV = 6'h10,
		S_RUN = 6'h20
	} state_t;
	typedef logic [NUM_LOOPS-1:0][SP_W-1:0] loop_vec_t;
	typedef struct packed {
		logic mode;
		logic [2:0] weekday;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] year;
	} as_t;
	typedef struct packed {
		logic [2:0] weekday;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] year;
	} tod_t;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [ADR_W-1:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} wb_rsp_t;
endpackage

// file: logic/profile_step_sequencer.sv
// Profile step sequencer with a classic Wishbone register slave.
`timescale 1ns/1ps
module profile_step_sequencer
	import sequencer_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire wb_req_t wb_in,
	output wb_rsp_t wb_out,
	input wire logic sec_tick_in,
	input wire tod_t tod_in,
	input wire loop_vec_t pv_in,
	output loop_vec_t setpoint_out,
	output logic [STEP_W-1:0] step_out,
	output logic running_out,
	output logic held_out,
	output logic done_out
);
	typedef struct packed {
		state_t st;
		logic [STEP_W-1:0] step;
		logic [STEP_W-1:0] idx;
		loop_vec_t base;
		loop_vec_t sp;
		logic [TIME_W-1:0] total;
		logic [TIME_W-1:0] remain;
		logic [TIME_W:0] rem;
		logic [FRAC_W-1:0] frac;
		logic [4:0] dcnt;
		logic wait_act;
		logic wait_up;
		logic done;
		logic frozen;
		logic hold;
		logic as_en;
		logic running;
		logic held;
		logic [STEP_W-1:0] nsteps;
		logic [STEP_W-1:0] start_step;
		loop_vec_t band;
		as_t as_saved;
		as_t as_run;
		logic ack;
		logic [31:0] dat;
	} seq_state_t;

	seq_state_t q;
	seq_state_t next_q;
	// ========================================================
	// Profile store: four words per step, plus live jump counters.
	logic [31:0] prog [0:MAX_STEPS-1][0:3];
	logic [7:0] jleft [0:MAX_STEPS-1];
	logic jl_we;
	logic [STEP_W-1:0] jl_addr;
	logic [7:0] jl_data;

	logic req;
	logic wr;
	logic [ADR_W-1:0] off;
	logic in_prog;
	logic [STEP_W-1:0] cur;
	logic [31:0] w0;
	logic [31:0] w1;
	logic [31:0] w2;
	logic [31:0] w3;
	logic [TIME_W-1:0] secs;
	logic [NUM_LOOPS-1:0] out_band;
	loop_vec_t target;
	loop_vec_t interp;
	logic [SP_W-1:0] wpv;
	logic wait_met;
	logic as_match;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b+:8] = v[8*b+:8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] time_word(input as_t a);
		return {7'h00, a.mode, 5'h00, a.weekday, a.hour, a.minute};
	endfunction

	function automatic logic [31:0] date_word(input as_t a);
		return {8'h00, a.year, a.day, a.month};
	endfunction

	assign req = wb_in.cyc & wb_in.stb & ~q.ack;
	assign wr = req & wb_in.we;
	assign off = wb_in.adr - STEP_BASE;
	assign in_prog = (wb_in.adr >= STEP_BASE) && (off[ADR_W-1:4] < 8'(MAX_STEPS));
	assign cur = q.step - 7'h01;
	assign w0 = prog[cur][0];
	assign w1 = prog[cur][1];
	assign w2 = prog[cur][2];
	assign w3 = prog[cur][3];
	assign secs = TIME_W'(w1[7:0]) * SECS_PER_HOUR + TIME_W'(w1[15:8]) * SECS_PER_MIN
		+ TIME_W'(w1[23:16]);
	assign wpv = pv_in[w2[17]];
	assign wait_met = q.wait_up ? ($signed(wpv) >= $signed(w3[15:0]))
		: ($signed(wpv) <= $signed(w3[15:0]));
	assign as_match = (tod_in.hour == q.as_run.hour) && (tod_in.minute == q.as_run.minute)
		&& (q.as_run.mode ? (tod_in.weekday == q.as_run.weekday)
		: ((tod_in.month == q.as_run.month) && (tod_in.day == q.as_run.day)
		&& (tod_in.year == q.as_run.year)));

	for (genvar i = 0; i < NUM_LOOPS; i++) begin : g_loop
		logic signed [SP_W:0] dev;
		logic [SP_W:0] mag;
		logic signed [SP_W:0] diff;
		logic signed [SP_W+FRAC_W+1:0] prod;
		assign target[i] = w0[SP_W*i+:SP_W];
		assign dev = $signed({pv_in[i][SP_W-1], pv_in[i]}) - $signed({q.sp[i][SP_W-1], q.sp[i]});
		assign mag = dev[SP_W] ? (SP_W+1)'(-dev) : dev;
		// Out of band per guarded loop; own band per loop; step enable.
		assign out_band[i] = w1[24+i] && (mag > {1'b0, q.band[i]});
		assign diff = $signed({target[i][SP_W-1], target[i]})
			- $signed({q.base[i][SP_W-1], q.base[i]});
		assign prod = diff * $signed({1'b0, q.frac});
		// Linear share of the step's change; zero change holds.
		assign interp[i] = q.base[i] + prod[SP_W+FRAC_W-1:FRAC_W];
	end

	always_comb begin
		logic fin;
		logic [31:0] v;
		logic [TIME_W:0] r2;
		fin = 1'b0;
		v = 32'h0000_0000;
		r2 = {q.rem[TIME_W-1:0], 1'b0};
		next_q = q;
		next_q.ack = req;
		jl_we = 1'b0;
		jl_addr = cur;
		jl_data = jleft[cur] - 8'h01;
		// ====================================================
		// Register reads.
		next_q.dat = 32'h0000_0000;
		if (req && !wb_in.we) begin
			if (in_prog) begin
				next_q.dat = prog[off[10:4]][off[3:2]];
			end else begin
				case (wb_in.adr)
					CTRL_ADDR: next_q.dat = {28'h0000_000, q.as_en, q.hold, 2'b00};
					CFG_ADDR: next_q.dat = {17'h00000, q.start_step, 1'b0, q.nsteps};
					BAND_ADDR: next_q.dat = q.band;
					AS_TIME_ADDR: next_q.dat = time_word(q.as_saved);
					AS_DATE_ADDR: next_q.dat = date_word(q.as_saved);
					RUN_TIME_ADDR: next_q.dat = time_word(q.as_run);
					RUN_DATE_ADDR: next_q.dat = date_word(q.as_run);
					STATUS_ADDR: next_q.dat = {jleft[cur], 4'h0, q.hold, q.frozen, q.wait_act,
						q.done, 1'b0, q.step, 2'b00, q.st};
					TIME_LEFT_ADDR: next_q.dat = {12'h000, q.remain};
					default: next_q.dat = 32'h0000_0000;
				endcase
			end
		end
		// ====================================================
		// Register writes.
		if (wr && !in_prog) begin
			case (wb_in.adr)
				CTRL_ADDR: begin
					if (wb_in.sel[0]) begin
						next_q.hold = wb_in.dat[CTRL_HOLD];
						next_q.as_en = wb_in.dat[CTRL_AS_EN];
						// Besides AS_TIME_ADDR and AS_DATE_ADDR writes, only an explicit save touches the stored copy.
						if (wb_in.dat[CTRL_SAVE]) begin
							next_q.as_saved = q.as_run;
						end
						if (wb_in.dat[CTRL_LOAD]) begin
							next_q.as_run = q.as_saved;
						end
					end
				end
				CFG_ADDR: begin
					v = merge({17'h00000, q.start_step, 1'b0, q.nsteps}, wb_in.dat, wb_in.sel);
					// Step counts limited to the store.
					if (v[6:0] != 7'h00 && v[6:0] <= 7'(MAX_STEPS)) begin
						next_q.nsteps = v[6:0];
					end
					if (v[14:8] != 7'h00 && v[14:8] <= 7'(MAX_STEPS)) begin
						next_q.start_step = v[14:8];
					end
				end
				// Bands held with the profile settings.
				BAND_ADDR: next_q.band = merge(q.band, wb_in.dat, wb_in.sel);
				AS_TIME_ADDR, RUN_TIME_ADDR: begin
					v = merge(time_word(wb_in.adr == AS_TIME_ADDR ? q.as_saved : q.as_run),
						wb_in.dat, wb_in.sel);
					if (wb_in.adr == AS_TIME_ADDR) begin
						{next_q.as_saved.mode, next_q.as_saved.weekday} = {v[24], v[18:16]};
						{next_q.as_saved.hour, next_q.as_saved.minute} = v[15:0];
					end else begin
						{next_q.as_run.mode, next_q.as_run.weekday} = {v[24], v[18:16]};
						{next_q.as_run.hour, next_q.as_run.minute} = v[15:0];
					end
				end
				AS_DATE_ADDR: begin
					v = merge(date_word(q.as_saved), wb_in.dat, wb_in.sel);
					{next_q.as_saved.year, next_q.as_saved.day, next_q.as_saved.month} = v[23:0];
				end
				RUN_DATE_ADDR: begin
					v = merge(date_word(q.as_run), wb_in.dat, wb_in.sel);
					{next_q.as_run.year, next_q.as_run.day, next_q.as_run.month} = v[23:0];
				end
				default: v = 32'h0000_0000;
			endcase
		end
		// ====================================================
		// Sequencer.
		case (q.st)
			S_IDLE: begin
				if (wr && !in_prog && wb_in.adr == CTRL_ADDR && wb_in.sel[0]
					&& wb_in.dat[CTRL_START]) begin
					next_q.done = 1'b0;
					next_q.idx = 7'h00;
					next_q.st = wb_in.dat[CTRL_AS_EN] ? S_AUTO : S_INIT;
				end
			end
			S_AUTO: begin
				if (as_match) begin
					next_q.st = S_INIT;
				end
			end
			S_INIT: begin
				jl_we = 1'b1;
				jl_addr = q.idx;
				jl_data = prog[q.idx][2][15:8];
				next_q.idx = q.idx + 7'h01;
				if (q.idx + 7'h01 >= q.nsteps) begin
					next_q.step = q.start_step;
					next_q.st = S_LOAD;
				end
			end
			S_LOAD: begin
				next_q.base = q.sp;
				next_q.total = secs;
				next_q.remain = secs;
				next_q.wait_act = w2[16];
				next_q.wait_up = $signed(wpv) < $signed(w3[15:0]);
				next_q.st = S_RUN;
				// Zero time steps straight to target.
				if (secs == 20'h00000) begin
					next_q.sp = target;
					next_q.wait_act = 1'b0;
					fin = 1'b1;
				end
			end
			S_DIV: begin
				// Serial divide: the fraction is only needed once per second.
				if (q.dcnt == DIV_LAST) begin
					next_q.sp = interp;
					next_q.st = S_RUN;
				end else begin
					next_q.dcnt = q.dcnt + 5'h01;
					if (r2 >= {1'b0, q.total}) begin
						next_q.rem = r2 - {1'b0, q.total};
						next_q.frac = {q.frac[FRAC_W-2:0], 1'b1};
					end else begin
						next_q.rem = r2;
						next_q.frac = {q.frac[FRAC_W-2:0], 1'b0};
					end
				end
			end
			S_RUN: begin
				if (q.wait_act && wait_met) begin
					next_q.wait_act = 1'b0;
				end
				// Timer stops while held, out of band or waiting.
				if (sec_tick_in && !q.hold && out_band == '0 && !q.wait_act) begin
					next_q.remain = q.remain - 20'h00001;
					if (q.remain == 20'h00001) begin
						next_q.sp = target;
						fin = 1'b1;
					end else begin
						next_q.rem = {1'b0, q.total - q.remain + 20'h00001};
						next_q.frac = '0;
						next_q.dcnt = 5'h00;
						next_q.st = S_DIV;
					end
				end
			end
			default: next_q.st = S_IDLE;
		endcase
		if (fin) begin
			// Jump only with a live count.
			if (w2[15:8] != 8'h00 && jleft[cur] != 8'h00) begin
				jl_we = 1'b1;
				next_q.step = w2[6:0];
				next_q.st = S_LOAD;
			end else if (q.step >= q.nsteps) begin
				next_q.st = S_IDLE;
				next_q.done = 1'b1;
			end else begin
				next_q.step = q.step + 7'h01;
				next_q.st = S_LOAD;
			end
		end
		if (wr && !in_prog && wb_in.adr == CTRL_ADDR && wb_in.sel[0]
			&& wb_in.dat[CTRL_STOP]) begin
			next_q.st = S_IDLE;
		end
		next_q.frozen = (q.st == S_RUN) && (out_band != '0);
		next_q.running = next_q.st != S_IDLE;
		next_q.held = next_q.running && (next_q.hold || next_q.frozen || next_q.wait_act);
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			q <= '0;
			q.st <= S_IDLE;
			q.step <= START_RST;
			q.nsteps <= NSTEPS_RST;
			q.start_step <= START_RST;
		end else begin
			q <= next_q;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (wr && in_prog) begin
			prog[off[10:4]][off[3:2]] <= merge(prog[off[10:4]][off[3:2]], wb_in.dat, wb_in.sel);
		end
		if (jl_we) begin
			jleft[jl_addr] <= jl_data;
		end
	end

	assign wb_out = '{ack: q.ack, dat: q.dat};
	assign setpoint_out = q.sp;
	assign step_out = q.step;
	assign running_out = q.running;
	assign held_out = q.held;
	assign done_out = q.done;
endmodule

// file: verification/loop_partner.sv
// Behavioural control loops and time-of-day source facing the sequencer.
`timescale 1ns/1ps
module loop_partner
	import sequencer_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic tick_en_in,
	input wire logic [SP_W-1:0] pv_off_in,
	input wire tod_t tod_set_in,
	input wire loop_vec_t setpoint_in,
	output logic sec_tick_out,
	output tod_t tod_out,
	output loop_vec_t pv_out
);
	logic [5:0] div = 6'h00;
	// one pulse per second
	// A second is shrunk to 64 cycles so the run stays short.
	always_ff @(posedge sys_clk_in) begin
		div <= tick_en_in ? div + 6'h01 : 6'h00;
	end
	assign sec_tick_out = tick_en_in && (div == 6'h3f);
	assign tod_out = tod_set_in;
	assign pv_out[0] = setpoint_in[0] + pv_off_in;
	assign pv_out[1] = setpoint_in[1];
endmodule

// file: verification/profile_step_sequencer_test.sv
// Self-checking bench for the profile step sequencer.
`timescale 1ns/1ps
module profile_step_sequencer_test
	import sequencer_pkg::*;
;
	logic sys_clk, resetn, tick, running, held, done, tick_en;
	wb_req_t wb_req;
	wb_rsp_t wb_rsp;
	tod_t tod, tod_set;
	loop_vec_t pv, sp, exp_sp;
	logic [STEP_W-1:0] step;
	logic [SP_W-1:0] pv_off, ta, tb, tc, td;
	logic [SP_W-1:0] e0[7], e1[7];
	int es[7] = '{1, 2, 2, 2, 2, 4, 4};
	logic [31:0] rd, seed;
	int bad_count, samples_checked;
	profile_step_sequencer profile_step_sequencer_inst (.sys_clk_in(sys_clk), .resetn_in(resetn),
		.wb_in(wb_req), .wb_out(wb_rsp), .sec_tick_in(tick), .tod_in(tod), .pv_in(pv),
		.setpoint_out(sp), .step_out(step), .running_out(running), .held_out(held),
		.done_out(done));
	loop_partner loop_partner_inst (.sys_clk_in(sys_clk), .tick_en_in(tick_en),
		.pv_off_in(pv_off), .tod_set_in(tod_set), .setpoint_in(sp), .sec_tick_out(tick),
		.tod_out(tod), .pv_out(pv));
	// ========================================================
	// Helpers.
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [SP_W-1:0] rnd_sp();
		seed = xs(seed);
		return {{4{seed[11]}}, seed[11:1], 1'b0};
	endfunction
	// Midpoint of a two-second ramp; even targets keep it exact.
	function automatic logic [SP_W-1:0] mid(input logic [SP_W-1:0] a, input logic [SP_W-1:0] b);
		return SP_W'((int'($signed(a)) + int'($signed(b))) / 2);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			bad_count++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic wb(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 50);
		rd = wb_rsp.dat;
		wb_req <= '0;
		@(posedge sys_clk);
		if (n >= 50) begin
			bad_count++;
			test_done();
		end
	endtask
	task automatic wait_tick();
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (tick !== 1'b1 && n < 200);
		if (n >= 200) begin
			bad_count++;
			test_done();
		end
		repeat (30) @(posedge sys_clk);
	endtask
	task automatic put_step(input int n, input logic [SP_W-1:0] t0, input logic [SP_W-1:0] t1,
		input logic [7:0] secs, input logic [1:0] guard, input logic [6:0] js, input logic [7:0] jc);
		logic [ADR_W-1:0] b;
		b = STEP_BASE + ADR_W'(16 * (n - 1));
		wb(1'b1, b, {t1, t0});
		wb(1'b1, b + 12'h004, {6'h00, guard, secs, 8'h00, 8'h00});
		wb(1'b1, b + 12'h008, {16'h0000, jc, 1'b0, js});
		wb(1'b1, b + 12'h00c, 32'h00000000);
	endtask
	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ========================================================
	// Clock, watchdog and main sequence.
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// The run needs about 1000 cycles; twenty times that marks a hang.
	initial begin
		#500000;
		bad_count++;
		test_done();
	end
	initial begin
		resetn <= 1'b0;
		wb_req <= '0;
		tick_en <= 1'b0;
		pv_off <= 16'h0000;
		tod_set <= '0;
		seed = 32'h0000748c;
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		wb(1'b0, STATUS_ADDR, 32'h0);
		check(rd & 32'h00ffffff, 32'h00000101);
		wb(1'b1, 12'h100, 32'hffffffff);
		wb(1'b0, 12'h100, 32'h0);
		check(rd, 32'h00000000);
		wb(1'b1, CFG_ADDR, 32'h00000104);
		wb(1'b1, CFG_ADDR, 32'h00000000);
		wb(1'b0, CFG_ADDR, 32'h0);
		check(rd, 32'h00000104);
		wb(1'b1, BAND_ADDR, 32'h0000000a);
		wb(1'b0, BAND_ADDR, 32'h0);
		check(rd, 32'h0000000a);
		wb(1'b1, RUN_TIME_ADDR, 32'h0003111e);
		wb(1'b0, AS_TIME_ADDR, 32'h0);
		check(rd, 32'h00000000);
		wb(1'b1, CTRL_ADDR, 32'h00000010);
		wb(1'b0, AS_TIME_ADDR, 32'h0);
		check(rd, 32'h0003111e);
		ta = rnd_sp();
		tb = rnd_sp();
		tc = rnd_sp();
		td = rnd_sp();
		put_step(1, ta, tc, 8'h02, 2'b00, 7'h00, 8'h00);
		put_step(2, ta, tc, 8'h02, 2'b01, 7'h00, 8'h00);
		put_step(3, tb, td, 8'h00, 2'b00, 7'h02, 8'h01);
		put_step(4, ta, tc, 8'h01, 2'b00, 7'h01, 8'h00);
		$display("register test done");
		for (int k = 0; k < 2; k++) begin
			wb(1'b1, RUN_TIME_ADDR, {7'h00, k[0], 5'h00, 3'h3, 8'h11, 8'h1e});
			wb(1'b1, RUN_DATE_ADDR, 32'h00180c07);
			tod_set <= {k[0] ? 3'h2 : 3'h3, 8'h11, 8'h1e, 8'h07, k[0] ? 8'h0c : 8'h0d, 8'h18};
			wb(1'b1, CTRL_ADDR, 32'h00000009);
			repeat (5) @(posedge sys_clk);
			wb(1'b0, STATUS_ADDR, 32'h0);
			check(rd & 32'h0000003f, 32'h00000002);
			tod_set <= {k[0] ? 3'h3 : 3'h5, 8'h11, 8'h1e, k[0] ? 8'h09 : 8'h07, 8'h0c, 8'h18};
			repeat (5) @(posedge sys_clk);
			wb(1'b0, STATUS_ADDR, 32'h0);
			check({31'h0, rd[5:0] == 6'h02}, 32'h0);
			wb(1'b1, CTRL_ADDR, 32'h00000002);
		end
		$display("autostart test done");
		e0 = '{mid(16'h0000, ta), ta, ta, tb, mid(tb, ta), tb, ta};
		e1 = '{mid(16'h0000, tc), tc, tc, td, mid(td, tc), td, tc};
		wb(1'b1, CTRL_ADDR, 32'h00000001);
		tick_en <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			wait_tick();
			exp_sp[0] = e0[i];
			exp_sp[1] = e1[i];
			check(sp, exp_sp);
			check({25'h0, step}, es[i]);
			for (int k = 0; k < 2 && i == 2; k++) begin
				if (k == 0) wb(1'b1, CTRL_ADDR, 32'h00000004);
				else pv_off <= 16'h000b;
				wait_tick();
				check({31'h0, held}, 32'h1);
				wb(1'b0, TIME_LEFT_ADDR, 32'h0);
				check(rd, 32'h00000001);
				if (k == 0) wb(1'b1, CTRL_ADDR, 32'h00000000);
				else pv_off <= 16'h000a;
			end
		end
		check({30'h0, done, running}, 32'h2);
		$display("profile run test done");
		// A one-step profile that must wait for loop zero to climb to its wait setpoint.
		wb(1'b1, CFG_ADDR, 32'h00000101);
		wb(1'b1, STEP_BASE + 12'h008, 32'h00010000);
		wb(1'b1, STEP_BASE + 12'h00c, {16'h0000, ta + 16'h0020});
		wb(1'b1, CTRL_ADDR, 32'h00000001);
		wait_tick();
		check({31'h0, held}, 32'h1);
		wb(1'b0, TIME_LEFT_ADDR, 32'h0);
		check(rd, 32'h00000002);
		pv_off <= 16'h0020;
		wait_tick();
		wait_tick();
		check({30'h0, done, running}, 32'h2);
		check(sp[0], {16'h0000, ta});
		$display("wait test done");
		test_done();
	end
endmodule

// file: verification/seq_checker_assertions.sv
// Port-level checks on the profile step sequencer.
`timescale 1ns/1ps
module seq_checker
	import sequencer_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire wb_req_t wb_in,
	input wire wb_rsp_t wb_out,
	input wire logic sec_tick_in,
	input wire tod_t tod_in,
	input wire loop_vec_t pv_in,
	input wire loop_vec_t setpoint_out,
	input wire logic [STEP_W-1:0] step_out,
	input wire logic running_out,
	input wire logic held_out,
	input wire logic done_out
);
	// ========================================================
	// Bus and sequencer properties.
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);
	a_ack_answer:
		assert property (wb_in.cyc && wb_in.stb && !wb_out.ack |=> wb_out.ack)
		else $error("ack missing after request");
	a_ack_single:
		assert property (wb_out.ack |=> !wb_out.ack)
		else $error("ack held longer than one cycle");
	a_rdata_quiet:
		assert property (!wb_out.ack |-> wb_out.dat == 32'h00000000)
		else $error("read data not zero outside ack");
	a_step_range:
		assert property (step_out >= 1 && step_out <= MAX_STEPS)
		else $error("step number out of range");
	a_done_stops:
		assert property (done_out |-> !running_out && !held_out)
		else $error("done while still running");
	a_held_running:
		assert property (held_out |-> running_out)
		else $error("held while not running");
	a_idle_setpoint:
		assert property (!running_out && $past(!running_out) |-> $stable(setpoint_out))
		else $error("setpoint moved while idle");
	a_done_clear:
		assert property ($fell(done_out) && $past(resetn_in) |-> running_out)
		else $error("done cleared without a start");
endmodule
bind profile_step_sequencer seq_checker seq_checker_inst (
	.sys_clk_in(sys_clk_in),
	.resetn_in(resetn_in),
	.wb_in(wb_in),
	.wb_out(wb_out),
	.sec_tick_in(sec_tick_in),
	.tod_in(tod_in),
	.pv_in(pv_in),
	.setpoint_out(setpoint_out),
	.step_out(step_out),
	.running_out(running_out),
	.held_out(held_out),
	.done_out(done_out)
);
